// [inc/fbpi_pkg.sv]
// Shared constants of the flash bus prefetch interface: register map,
// field layout, reset values, split codes and controller states.
// Assumes a 32-bit classic Wishbone register port and one system clock.
package fbpi_pkg;

   // Register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;   // Flash interface control
   localparam logic [7:0] ADR_CTRL2 = 8'h04;  // Line buffer split control
   localparam logic [7:0] ADR_STAT = 8'h08;   // Read-only controller state

   // Control register field positions
   localparam int F_RWS_LSB = 0;    // Read wait states, 3 bits
   localparam int F_APC_LSB = 4;    // Address pipelining, 2 bits
   localparam int F_WWS_LSB = 6;    // Write wait states, 2 bits
   localparam int F_PREFETCH_LIMIT_LSB = 8;  // Prefetch limit, 3 bits
   localparam int F_DPF_BIT = 11;   // Data prefetch on
   localparam int F_IPF_BIT = 12;   // Instruction prefetch on
   localparam int F_BUF_BIT = 13;   // Line buffers on
   localparam int F_MASK_LSB = 16;  // Master prefetch enable mask, 4 bits
   localparam int F_SPLIT_LSB = 0;  // Split field in second control reg

   // Reset: seven read wait states, slowest pipelining, prefetch off
   localparam logic [31:0] CTRL_RESET = 32'h0000_00F7;
   localparam logic [31:0] CTRL_WMASK = 32'h000F_3FF7;
   localparam logic [31:0] CTRL2_WMASK = 32'h0000_0003;

   // Shadow read uses the reset timing: 7 read plus 3 pipeline cycles
   localparam logic [3:0] SHADOW_WAIT = 4'hA;

   // Line buffer split codes
   localparam logic [1:0] SPLIT_ANY = 2'h0;    // Any buffer serves any access
   localparam logic [1:0] SPLIT_HALF = 2'h1;   // Lower half instr, upper half data
   localparam logic [1:0] SPLIT_ONE_I = 2'h2;  // Buffer 0 instr, rest data
   localparam logic [1:0] SPLIT_ONE_D = 2'h3;  // Last buffer data, rest instr

   // Sequencer states, one-hot
   typedef enum logic [3:0]
   {
      ST_SHADOW = 4'h1,
      ST_IDLE = 4'h2,
      ST_FETCH = 4'h4,
      ST_PREF = 4'h8
   } fbpi_state_e;

endpackage

// [hw/fbpi_skid.sv]
// Two-entry response buffer with valid and ready on both sides.
// Assumes source and sink share the clock; data leaves from flip-flops.
`timescale 1ns/1ns
module fbpi_skid #(
   parameter int W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);

   logic [W-1:0] mem_ff [2];  // Two storage slots
   logic rd_ff;               // Read slot
   logic wr_ff;               // Write slot
   logic [1:0] cnt_ff;        // Occupancy 0..2

   // Handshake decode
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = (cnt_ff != 2'h2);
   assign out_valid_o = (cnt_ff != 2'h0);
   assign out_data_o = mem_ff[rd_ff];

   ////////////////////////////////////////////////////////////////////////
   // Storage: written only on accepted push
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_ff[wr_ff] <= in_data_i;
      end
   end

   // Pointers and count; a stalled sink fills both slots, then refuses
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ff <= ~wr_ff;
         if (pop)
            rd_ff <= ~rd_ff;
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

// [hw/fbpi_regs.sv]
// Wishbone classic slave holding the two control registers and status.
// Assumes a same-clock master; exec_from_flash_i comes from local logic.
`timescale 1ns/1ns
module fbpi_regs
   import fbpi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic exec_from_flash_i,
   input wire logic split_load_i,
   input wire logic [1:0] split_val_i,
   input wire logic [31:0] status_i,
   output logic [31:0] ctrl_o,
   output logic [1:0] split_o
);

   import fbpi_pkg::*;

   logic [31:0] ctrl_ff;   // Flash interface control register
   logic [31:0] ctrl2_ff;  // Second control register, split field
   logic ack_ff;           // One-cycle acknowledge
   logic [31:0] dat_ff;    // Registered read data

   // Byte-lane merge limited to writable bits
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel, input logic [31:0] wmask);
      logic [31:0] lanes;
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
      return (old & ~lanes) | (nw & lanes);
   endfunction

   // Address decode; ack comes one cycle after the request and drops next
   wire req = wb_cyc_i && wb_stb_i && !ack_ff;
   wire hit_ctrl = (wb_adr_i == ADR_CTRL);
   wire hit_ctrl2 = (wb_adr_i == ADR_CTRL2);
   wire hit_stat = (wb_adr_i == ADR_STAT);
   wire wr_ok = req && wb_we_i && !exec_from_flash_i;
   wire [31:0] rd_mux = hit_ctrl ? ctrl_ff : hit_ctrl2 ? ctrl2_ff : hit_stat ? status_i : 32'h0000_0000;

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign ctrl_o = ctrl_ff;
   assign split_o = ctrl2_ff[F_SPLIT_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake and read data; unmapped reads return zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= req;
         if (req && !wb_we_i)
            dat_ff <= rd_mux;
      end
   end

   // Control registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_ff <= CTRL_RESET;
         ctrl2_ff <= 32'h0000_0000;
      end
      else
      begin
         if (wr_ok && hit_ctrl)
            ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i, CTRL_WMASK);
         if (split_load_i)
            ctrl2_ff[F_SPLIT_LSB +: 2] <= split_val_i;
         else if (wr_ok && hit_ctrl2)
            ctrl2_ff <= merge(ctrl2_ff, wb_dat_i, wb_sel_i, CTRL2_WMASK);
      end
   end

endmodule

// [hw/fbpi_top.sv]
// Flash bus prefetch interface: line buffers, prefetch sequencer,
// flash array port and register slave.
// Assumes same-clock bus masters and a flash controller that returns the
// addressed line once the programmed wait states have elapsed.
//
// Function
// - Serve bus reads by fetching flash lines
// - Prefetch next sequential lines when enabled
// - Buffer hits answered with zero wait
// - Control register sets timing and prefetching
// - Reset: prefetch off, seven wait states
// - Flash-executed code cannot change control
// - Buffers off means reads bypass them
// - Split field divides instruction/data buffers
// - Split default loaded from shadow row
// - Split zero: all buffers shared
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module fbpi_top
   import fbpi_pkg::*;
#(
   parameter int AW = 24,                     // Word address width
   parameter int LINE_W = 64,                 // Flash line width
   parameter int NBUF = 4,                    // Line buffers
   parameter int NMST = 4,                    // Bus masters in the mask
   parameter logic [22:0] SHADOW_LINE = 23'h7F_FFFF  // Line holding the split default
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic exec_from_flash_i,
   // System bus read request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [AW-1:0] req_addr_i,
   input wire logic req_instr_i,
   input wire logic [1:0] req_master_i,
   // Read response
   output logic rsp_valid_o,
   input wire logic rsp_ready_i,
   output logic [31:0] rsp_data_o,
   // Flash array controller
   output logic fl_rd_o,
   output logic [AW-2:0] fl_addr_o,
   input wire logic [LINE_W-1:0] fl_line_i
);

   import fbpi_pkg::*;

   localparam int WPL = LINE_W / 32;       // Words per line
   localparam int WS = $clog2(WPL);        // Word select bits
   localparam int LAW = AW - WS;           // Line address bits
   localparam int BI = $clog2(NBUF);       // Buffer index bits

   ////////////////////////////////////////////////////////////////////////
   // State

   fbpi_state_e state_ff;                  // Sequencer state
   fbpi_state_e nxt_state;
   logic [LAW-1:0] tag_ff [NBUF];          // Line held per buffer
   logic [LINE_W-1:0] line_ff [NBUF];      // Line data per buffer
   logic [NBUF-1:0] vld_ff;                // Buffer holds a line
   logic [NBUF-1:0] cls_ff;                // Buffer filled for instruction side
   logic [LAW-1:0] cur_line_ff;            // Line being fetched or last used
   logic [WS-1:0] cur_word_ff;             // Word wanted by a pending miss
   logic cur_instr_ff;                     // Class of the current stream
   logic [1:0] cur_mst_ff;                 // Master of the current stream
   logic [3:0] wait_ff;                    // Remaining wait cycles
   logic [2:0] pf_cnt_ff;                  // Lines prefetched in this run
   logic [BI-1:0] rr_ff;                   // Replacement pointer

   logic [31:0] ctrl;                      // Control register contents
   logic [1:0] split;                      // Buffer split field
   logic skid_rdy;                         // Response buffer has room
   logic push;                             // Word into response buffer
   logic [31:0] push_data;

   ////////////////////////////////////////////////////////////////////////
   // Control field decode

   wire [2:0] rws = ctrl[F_RWS_LSB +: 3];
   wire [1:0] address_pipeline_ctrl = ctrl[F_APC_LSB +: 2];
   wire [2:0] prefetch_limit = ctrl[F_PREFETCH_LIMIT_LSB +: 3];
   wire [NMST-1:0] pf_mask = ctrl[F_MASK_LSB +: NMST];
   wire buf_on = ctrl[F_BUF_BIT];
   wire [3:0] wait_load = {1'b0, rws} + {2'b00, address_pipeline_ctrl};

   // Whether buffer i may serve an access of the given class
   function automatic logic buf_ok(input int i, input logic instr, input logic [1:0] sp);
      logic r;
      unique case (sp)
         SPLIT_ANY: r = 1'b1;
         SPLIT_HALF: r = instr ? (i < NBUF / 2) : (i >= NBUF / 2);
         SPLIT_ONE_I: r = instr ? (i == 0) : (i != 0);
         SPLIT_ONE_D: r = instr ? (i != NBUF - 1) : (i == NBUF - 1);
      endcase
      return r;
   endfunction

   // Word of a line
   function automatic logic [31:0] word_of(input logic [LINE_W-1:0] ln, input logic [WS-1:0] w);
      return ln[w * 32 +: 32];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Request decode

   wire [LAW-1:0] req_line = req_addr_i[AW-1:WS];
   wire [WS-1:0] req_word = req_addr_i[WS-1:0];
   wire st_idle = (state_ff == ST_IDLE);
   // Next sequential line candidate for a prefetch
   wire [LAW-1:0] cand_line = (st_idle ? req_line : cur_line_ff) + 1'b1;
   wire cand_instr = st_idle ? req_instr_i : cur_instr_ff;
   wire [1:0] cand_mst = st_idle ? req_master_i : cur_mst_ff;
   wire cand_pf_on = cand_instr ? ctrl[F_IPF_BIT] : ctrl[F_DPF_BIT];

   logic [NBUF-1:0] hit_vec;   // Request line found per buffer
   logic [NBUF-1:0] cand_vec;  // Prefetch candidate already held
   logic [BI-1:0] hit_idx;
   logic [BI-1:0] vic_idx;     // Buffer to fill next

   // Lookup of the request and of the prefetch candidate
   always_comb
   begin
      hit_vec = '0;
      cand_vec = '0;
      hit_idx = '0;
      for (int i = 0; i < NBUF; i++)
      begin
         hit_vec[i] = buf_on && vld_ff[i] && (tag_ff[i] == req_line) && buf_ok(i, req_instr_i, split);
         cand_vec[i] = vld_ff[i] && (tag_ff[i] == cand_line) && buf_ok(i, cand_instr, split);
         if (hit_vec[i])
            hit_idx = BI'(i);
      end
   end

   // Victim: first free allowed buffer, else next allowed from the pointer
   always_comb
   begin
      logic found;
      int j;
      found = 1'b0;
      j = 0;
      vic_idx = rr_ff;
      for (int i = 0; i < NBUF; i++)
      begin
         if (!found && !vld_ff[i] && buf_ok(i, cur_instr_ff, split))
         begin
            vic_idx = BI'(i);
            found = 1'b1;
         end
      end
      for (int k = 0; k < NBUF; k++)
      begin
         j = (int'(rr_ff) + k) % NBUF;
         if (!found && buf_ok(j, cur_instr_ff, split))
         begin
            vic_idx = BI'(j);
            found = 1'b1;
         end
      end
   end

   // A take starts a fresh run, so the count of the last run must not gate it
   wire [2:0] pf_run = st_idle ? 3'h0 : pf_cnt_ff;
   wire pf_go = buf_on && cand_pf_on && pf_mask[cand_mst] && (pf_run < prefetch_limit) && !(|cand_vec);
   wire req_hit = |hit_vec;
   wire take = st_idle && req_valid_i && skid_rdy;
   wire line_done = (wait_ff == 4'h0);
   wire fetch_end = (state_ff == ST_FETCH) && line_done && skid_rdy;
   wire pref_end = (state_ff == ST_PREF) && line_done;
   wire shadow_end = (state_ff == ST_SHADOW) && line_done;
   wire fill = buf_on && (fetch_end || pref_end);

   // Requests wait while a prefetch runs; trades latency for a simple port
   assign req_ready_o = st_idle && skid_rdy;
   assign push = (take && req_hit) || fetch_end;
   assign push_data = fetch_end ? word_of(fl_line_i, cur_word_ff) : word_of(line_ff[hit_idx], req_word);
   assign fl_rd_o = !st_idle;
   assign fl_addr_o = cur_line_ff;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_SHADOW:
            if (shadow_end)
               nxt_state = ST_IDLE;
         ST_IDLE:
            if (take)
               nxt_state = !req_hit ? ST_FETCH : (pf_go ? ST_PREF : ST_IDLE);
         ST_FETCH:
            if (fetch_end)
               nxt_state = pf_go ? ST_PREF : ST_IDLE;
         ST_PREF:
            if (pref_end)
               nxt_state = pf_go ? ST_PREF : ST_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= ST_SHADOW;
         cur_line_ff <= SHADOW_LINE[LAW-1:0];
         cur_word_ff <= '0;
         cur_instr_ff <= 1'b0;
         cur_mst_ff <= 2'h0;
         wait_ff <= SHADOW_WAIT;
         pf_cnt_ff <= 3'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (!line_done)
            wait_ff <= wait_ff - 4'h1;
         if (take)
         begin
            cur_line_ff <= req_line;
            cur_word_ff <= req_word;
            cur_instr_ff <= req_instr_i;
            cur_mst_ff <= req_master_i;
            wait_ff <= wait_load;
            pf_cnt_ff <= 3'h0;
            if (req_hit && pf_go)
               cur_line_ff <= cand_line;
         end
         else if ((fetch_end || pref_end) && pf_go)
         begin
            cur_line_ff <= cand_line;
            wait_ff <= wait_load;
         end
         if (nxt_state == ST_PREF && (take || fetch_end || pref_end))
            pf_cnt_ff <= (take ? 3'h0 : pf_cnt_ff) + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line buffers; clearing the enable drops every held line
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vld_ff <= '0;
         cls_ff <= '0;
         rr_ff <= '0;
      end
      else if (!buf_on)
      begin
         vld_ff <= '0;
      end
      else if (fill)
      begin
         vld_ff[vic_idx] <= 1'b1;
         cls_ff[vic_idx] <= cur_instr_ff;
         rr_ff <= vic_idx + 1'b1;
      end
   end

   // Buffer contents
   always_ff @(posedge clk_i)
   begin
      if (fill)
      begin
         tag_ff[vic_idx] <= cur_line_ff;
         line_ff[vic_idx] <= fl_line_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register slave; status shows state, prefetch run and buffer use
   fbpi_regs u_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .exec_from_flash_i(exec_from_flash_i),
      .split_load_i(shadow_end),
      .split_val_i(fl_line_i[F_SPLIT_LSB +: 2]),
      .status_i({8'h00, 8'(cls_ff), 8'(vld_ff), 1'b0, pf_cnt_ff, state_ff}),
      .ctrl_o(ctrl),
      .split_o(split)
   );

   // Response buffer so a stalled requester loses no word
   fbpi_skid #(
      .W(32)
   ) u_skid (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_ready_o(skid_rdy),
      .in_data_i(push_data),
      .out_valid_o(rsp_valid_o),
      .out_ready_i(rsp_ready_i),
      .out_data_o(rsp_data_o)
   );

endmodule

// [bench/fbpi_props.sv]
// Port checker for the flash bus prefetch interface.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module fbpi_props #(
   parameter int AW = 24,
   parameter logic [22:0] SHADOW_LINE = 23'h7F_FFFF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic rsp_ready_i,
   input wire logic [31:0] rsp_data_o,
   input wire logic fl_rd_o,
   input wire logic [AW-2:0] fl_addr_o
);
   // One domain, so clock and reset are given once
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_ACK_NEXT: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("register access not acked");
   AST_ACK_PULSE: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   AST_ACK_IDLE: assert property (
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   AST_SHADOW_ADDR: assert property (
      $fell(rst_i) |=> fl_rd_o && fl_addr_o == SHADOW_LINE) else $error("no shadow line fetch");
   AST_SHADOW_BLOCK: assert property (
      $fell(rst_i) |-> !req_ready_o [*8]) else $error("request accepted during shadow load");
   AST_SHADOW_READY: assert property (
      $fell(rst_i) |-> ##[10:13] req_ready_o) else $error("not ready after shadow load");
   // Apart from the shadow load after reset, an array access only ever starts from a taken request
   AST_FETCH_CAUSE: assert property (
      $rose(fl_rd_o) |-> $past(req_valid_i) && $past(req_ready_o)) else $error("array fetch without request");
   AST_RSP_HOLD: assert property (
      rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o)) else $error("stalled word lost");
   AST_TAKE_ANSWER: assert property (
      req_valid_i && req_ready_o |-> ##[1:12] rsp_valid_o) else $error("request not answered");
endmodule

bind fbpi_top fbpi_props #(.AW(AW), .SHADOW_LINE(SHADOW_LINE)) fbpi_props_i (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .req_valid_i, .req_ready_o, .rsp_valid_o, .rsp_ready_i, .rsp_data_o, .fl_rd_o,
   .fl_addr_o);

// [bench/fbpi_flash_model.sv]
// Flash array controller model: each line is a pattern of its address.
// Assumes the unit samples the line on the last cycle of a fetch.
`timescale 1ns/1ns
module fbpi_flash_model (
   input wire logic clk_i,
   input wire logic fl_rd_i,
   input wire logic [22:0] fl_addr_i,
   output logic [63:0] fl_line_o
);
   logic [63:0] last_ff = 64'h0; // Line shown in the last fetch
   logic [63:0] line_w; // Addressed line
   assign line_w = {9'h1FF, fl_addr_i, 9'h000, fl_addr_i};
   // Between fetches the bus is not driven, so never show a stale line
   assign fl_line_o = fl_rd_i ? line_w : ~last_ff;
   // Remember what was shown
   always_ff @(posedge clk_i)
   begin
      if (fl_rd_i)
         last_ff <= line_w;
   end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the flash bus prefetch interface.
// Assumes the flash model answers fetches with address patterns.
`timescale 1ns/1ns
module tb_top;
   import fbpi_pkg::*;
   logic clk_i = 1'b0; // 10 MHz clock
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic exec_from_flash_i = 1'b0; // High: write from flash code
   logic req_valid_i = 1'b0;
   logic req_ready_o;
   logic [23:0] req_addr_i = 24'h0;
   logic req_instr_i = 1'b0;
   logic [1:0] req_master_i = 2'h2;
   logic rsp_valid_o;
   logic rsp_ready_i = 1'b1;
   logic [31:0] rsp_data_o;
   logic fl_rd_o;
   logic [22:0] fl_addr_o;
   logic [63:0] fl_line_i;
   int num_errors = 0;
   int checks_done = 0;
   logic [31:0] q; // Last register read

   always #50 clk_i = ~clk_i;

   fbpi_top fbpi_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .exec_from_flash_i, .req_valid_i, .req_ready_o, .req_addr_i, .req_instr_i,
      .req_master_i, .rsp_valid_o, .rsp_ready_i, .rsp_data_o, .fl_rd_o, .fl_addr_o, .fl_line_i);
   fbpi_flash_model fbpi_flash_model_i (.clk_i(clk_i), .fl_rd_i(fl_rd_o), .fl_addr_i(fl_addr_o),
      .fl_line_o(fl_line_i));

   ////////////////////////////////////////////////////////////////////////
   // Compare and verdict
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Word the model returns for a word address
   function automatic logic [31:0] word_of(input logic [23:0] a);
      return a[0] ? {9'h1FF, a[23:1]} : {9'h000, a[23:1]};
   endfunction
   // Classic cycle; request held until the ack edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // Hold a request until ready is seen, then drop it
   task automatic take(input logic [23:0] a);
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_addr_i <= a;
      do @(negedge clk_i); while (req_ready_o !== 1'b1);
      @(posedge clk_i);
      req_valid_i <= 1'b0;
   endtask
   // Request, then count cycles until the word appears
   task automatic rd(input logic [23:0] a, input int lat);
      int n;
      n = 0;
      take(a);
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (rsp_valid_o !== 1'b1 && n < 40);
      chk(n, lat);
      chk(rsp_data_o, word_of(a));
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset values, slow miss, shadow split, unmapped place
   task automatic t_reset();
      wb(1'b0, ADR_CTRL, 32'h0);
      chk(q, CTRL_RESET);
      rd(24'h000010, 12);
      wb(1'b0, ADR_CTRL2, 32'h0);
      chk(q, 32'h3);
      wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      wb(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0);
   endtask
   // Writes from flash-resident code are ignored
   task automatic t_protect();
      @(posedge clk_i);
      exec_from_flash_i <= 1'b1;
      wb(1'b1, ADR_CTRL, 32'h000F_3E40);
      exec_from_flash_i <= 1'b0;
      wb(1'b0, ADR_CTRL, 32'h0);
      chk(q, CTRL_RESET);
   endtask
   // Every split code, ending shared
   task automatic t_split();
      for (int k = 3; k >= 0; k--)
      begin
         wb(1'b1, ADR_CTRL2, 32'(k));
         wb(1'b0, ADR_CTRL2, 32'h0);
         chk(q, 32'(k));
      end
   endtask
   // Buffers on, no prefetch: miss, hit, then stall with two hits
   task automatic t_hit();
      wb(1'b1, ADR_CTRL, 32'h0000_2040);
      wb(1'b0, ADR_CTRL, 32'h0);
      chk(q, 32'h0000_2040);
      rd(24'h000100, 2);
      rd(24'h000101, 1);
      @(posedge clk_i);
      rsp_ready_i <= 1'b0;
      take(24'h000100);
      take(24'h000101);
      @(negedge clk_i);
      chk(req_ready_o, 1'b0);
      chk(rsp_data_o, word_of(24'h000100));
      @(posedge clk_i);
      rsp_ready_i <= 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
      chk(rsp_data_o, word_of(24'h000101));
   endtask
   // Prefetch of one line ahead, instruction side
   task automatic t_pref();
      // limit one line keeps hits deterministic
      wb(1'b1, ADR_CTRL, 32'h000F_3940);
      @(posedge clk_i);
      req_instr_i <= 1'b1;
      rd(24'h000200, 2);
      rd(24'h000202, 1);
      rd(24'h000204, 1);
   endtask
   // Half split: a line held only in a data buffer misses for instructions
   task automatic t_split_use();
      wb(1'b1, ADR_CTRL2, {30'h0, SPLIT_HALF});
      rd(24'h000204, 2);
      @(posedge clk_i);
      req_instr_i <= 1'b0;
      rd(24'h000205, 1);
      wb(1'b1, ADR_CTRL2, {30'h0, SPLIT_ANY});
      wb(1'b0, ADR_CTRL2, 32'h0);
      chk(q, 32'h0);
   endtask
   // Buffers off: every read goes to the array
   task automatic t_bypass();
      wb(1'b1, ADR_CTRL, 32'h0000_0040);
      rd(24'h000204, 2);
      rd(24'h000205, 2);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_protect();
      t_split();
      t_hit();
      t_pref();
      t_split_use();
      t_bypass();
      tally_and_finish();
   end
   // Watchdog: the tests need well under a thousand cycles
   initial
   begin
      #1000000;
      num_errors++;
      tally_and_finish();
   end
endmodule
